// [rtl/alex_pkg.sv]
// shared constants and types of the alu execution block
package alex_pkg;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_OPER = 8'h04;
	localparam logic [7:0] OFS_OFFSET = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0c;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_REGWR = 8'h18;
	localparam logic [7:0] OFS_PEEK = 8'h1c;

	// field positions
	localparam int OPER_DEST_LSB = 0;
	localparam int OPER_SRC_LSB = 8;
	localparam int OPER_IMM_LSB = 16;
	localparam int REG_IDX_LSB = 8;
	localparam int STAT_RES_LSB = 8;

	// reset values
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [5:0] FLAGS_RST = 6'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// pointer pair used by the indirect jump and call
	localparam logic [4:0] Z_LO_IDX = 5'h1e;
	localparam logic [4:0] Z_HI_IDX = 5'h1f;

	// operation codes
	localparam logic [4:0] OP_ADD = 5'h00;
	localparam logic [4:0] OP_ADC = 5'h01;
	localparam logic [4:0] OP_ADDW = 5'h02;
	localparam logic [4:0] OP_SUB = 5'h03;
	localparam logic [4:0] OP_SUBK = 5'h04;
	localparam logic [4:0] OP_SUBW = 5'h05;
	localparam logic [4:0] OP_SBC = 5'h06;
	localparam logic [4:0] OP_SBCK = 5'h07;
	localparam logic [4:0] OP_AND = 5'h08;
	localparam logic [4:0] OP_ANDK = 5'h09;
	localparam logic [4:0] OP_OR = 5'h0a;
	localparam logic [4:0] OP_ORK = 5'h0b;
	localparam logic [4:0] OP_XOR = 5'h0c;
	localparam logic [4:0] OP_ONES = 5'h0d;
	localparam logic [4:0] OP_NEG = 5'h0e;
	localparam logic [4:0] OP_SETB = 5'h0f;
	localparam logic [4:0] OP_CLRB = 5'h10;
	localparam logic [4:0] OP_INC = 5'h11;
	localparam logic [4:0] OP_DEC = 5'h12;
	localparam logic [4:0] OP_TEST = 5'h13;
	localparam logic [4:0] OP_CLR = 5'h14;
	localparam logic [4:0] OP_SETR = 5'h15;
	localparam logic [4:0] OP_JREL = 5'h16;
	localparam logic [4:0] OP_JIND = 5'h17;
	localparam logic [4:0] OP_CREL = 5'h18;
	localparam logic [4:0] OP_CIND = 5'h19;
	localparam logic [4:0] OP_LAST = OP_CIND;

	// flag update masks, bit order h s v n z c
	localparam logic [5:0] FM_ARITH = 6'h2f;
	localparam logic [5:0] FM_WORD = 6'h1f;
	localparam logic [5:0] FM_LOGIC = 6'h0e;
	localparam logic [5:0] FM_ONES = 6'h0f;
	localparam logic [5:0] FM_NONE = 6'h00;

	// execution cycle counts
	localparam int CYC_WORD = 2;
	localparam int CYC_JUMP = 2;
	localparam int CYC_CALL = 3;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FETCH = 4'h2,
		ST_EXEC = 4'h4,
		ST_WAIT = 4'h8
	} alex_state_e;

	typedef struct packed {
		logic h;
		logic s;
		logic v;
		logic n;
		logic z;
		logic c;
	} alex_flags_s;

	typedef struct packed {
		logic [7:0] imm;
		logic [4:0] src;
		logic [4:0] dest;
	} alex_operands_s;

	function automatic logic [31:0] merge_strb(input logic [31:0] cur,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (cur & ~m) | (wd & m);
	endfunction
endpackage

// [rtl/alex_regfile.sv]
// working register file, 32 bytes, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module alex_regfile (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [4:0] addr_a,
	input wire logic [4:0] addr_b,
	output logic [7:0] rd_a,
	output logic [7:0] rd_b,
	input wire logic we,
	input wire logic [4:0] waddr,
	input wire logic [7:0] wdata
);
	logic [7:0] mem [0:31];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read data lag the address by one edge; old data on a same-edge write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_a <= 8'h00;
			rd_b <= 8'h00;
		end else begin
			rd_a <= mem[addr_a];
			rd_b <= mem[addr_b];
		end
	end
endmodule // alex_regfile
`default_nettype wire

// [rtl/alex_core.sv]
// alu execution block with register file and axi4-lite control
`timescale 1ns/1ps
`default_nettype none
module alex_core (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [alex_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [alex_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	alex_pkg::alex_state_e state;
	alex_pkg::alex_state_e next_state;
	alex_pkg::alex_operands_s opr;
	alex_pkg::alex_flags_s flags;
	logic [4:0] op;
	logic [11:0] offset;
	logic [15:0] pc;
	logic [1:0] cnt;
	logic [7:0] lo_res;
	logic lo_carry;
	logic [7:0] last_res;
	logic bad_op;
	logic [4:0] peek_idx;
	logic aw_held;
	logic w_held;
	logic [alex_pkg::ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [7:0] rd_a;
	logic [7:0] rd_b;

	wire idle = (state == alex_pkg::ST_IDLE);
	wire st_exec = (state == alex_pkg::ST_EXEC);
	wire st_wait = (state == alex_pkg::ST_WAIT);

	// operation decode
	wire o_add = (op == alex_pkg::OP_ADD);
	wire o_adc = (op == alex_pkg::OP_ADC);
	wire o_addw = (op == alex_pkg::OP_ADDW);
	wire o_sub = (op == alex_pkg::OP_SUB);
	wire o_subk = (op == alex_pkg::OP_SUBK);
	wire o_subw = (op == alex_pkg::OP_SUBW);
	wire o_sbc = (op == alex_pkg::OP_SBC);
	wire o_sbck = (op == alex_pkg::OP_SBCK);
	wire o_ones = (op == alex_pkg::OP_ONES);
	wire o_neg = (op == alex_pkg::OP_NEG);
	wire o_inc = (op == alex_pkg::OP_INC);
	wire o_dec = (op == alex_pkg::OP_DEC);
	wire o_test = (op == alex_pkg::OP_TEST);
	wire o_clr = (op == alex_pkg::OP_CLR);
	wire o_setr = (op == alex_pkg::OP_SETR);
	wire o_clrb = (op == alex_pkg::OP_CLRB);
	wire o_and = (op == alex_pkg::OP_AND) | (op == alex_pkg::OP_ANDK) | o_test;
	wire o_or = (op == alex_pkg::OP_OR) | (op == alex_pkg::OP_ORK)
		| (op == alex_pkg::OP_SETB);
	wire o_xor = (op == alex_pkg::OP_XOR) | o_clr;
	wire o_jrel = (op == alex_pkg::OP_JREL) | (op == alex_pkg::OP_CREL);
	wire o_jind = (op == alex_pkg::OP_JIND) | (op == alex_pkg::OP_CIND);
	wire o_call = (op == alex_pkg::OP_CREL) | (op == alex_pkg::OP_CIND);
	wire o_jump = o_jrel | o_jind;
	wire o_word = o_addw | o_subw;
	wire o_imm = o_subk | o_sbck | o_word | (op == alex_pkg::OP_ANDK)
		| (op == alex_pkg::OP_ORK) | (op == alex_pkg::OP_SETB) | o_clrb;
	wire o_subtr = o_sub | o_subk | o_subw | o_sbc | o_sbck | o_ones
		| o_neg | o_dec;
	wire o_arith = o_add | o_adc | o_subtr | o_inc | o_word;
	wire o_full = o_add | o_adc | o_sub | o_subk | o_sbc | o_sbck | o_neg;
	wire o_logic = o_and | o_or | o_xor | o_clrb | o_inc | o_dec;

	// register file addressing: peek while idle, operands while busy
	wire [4:0] dest_hi = opr.dest + 5'h01;
	wire [4:0] ra_addr = idle ? peek_idx
		: (o_jind ? alex_pkg::Z_LO_IDX : opr.dest);
	wire [4:0] rb_addr = o_jind ? alex_pkg::Z_HI_IDX
		: (o_word ? dest_hi : opr.src);

	// operand selection; second word cycle runs the upper byte
	// carry into upper byte
	wire [7:0] op_a = st_wait ? rd_b
		: (o_neg ? 8'h00 : (o_ones ? 8'hff : rd_a));
	wire [7:0] op_b = st_wait ? 8'h00
		: (o_imm ? opr.imm : ((o_inc | o_dec) ? 8'h01
		: ((o_neg | o_ones | o_test | o_clr) ? rd_a : rd_b)));
	wire op_cin = st_wait ? lo_carry : ((o_adc | o_sbc | o_sbck) & flags.c);

	wire [8:0] add_sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, op_cin};
	wire [8:0] sub_dif = {1'b0, op_a} - {1'b0, op_b} - {8'h00, op_cin};
	wire [8:0] arith = o_subtr ? sub_dif : add_sum;
	wire [7:0] r = arith[7:0];
	wire h_add = (op_a[3] & op_b[3]) | (op_b[3] & ~r[3]) | (~r[3] & op_a[3]);
	wire h_sub = (~op_a[3] & op_b[3]) | (op_b[3] & r[3]) | (r[3] & ~op_a[3]);
	wire v_add = (op_a[7] & op_b[7] & ~r[7]) | (~op_a[7] & ~op_b[7] & r[7]);
	wire v_sub = (op_a[7] & ~op_b[7] & ~r[7]) | (~op_a[7] & op_b[7] & r[7]);

	wire [7:0] logic_res = o_and ? (rd_a & op_b)
		: (o_or ? (rd_a | op_b)
		: (o_xor ? (rd_a ^ op_b)
		: (o_clrb ? (rd_a & ~opr.imm) : 8'hff)));
	wire [7:0] res8 = o_arith ? r : logic_res;

	// new flag values before masking
	alex_pkg::alex_flags_s new_flags;
	assign new_flags.c = o_ones | arith[8];
	assign new_flags.h = o_subtr ? h_sub : h_add;
	assign new_flags.v = (o_arith && !o_ones) ? (o_subtr ? v_sub : v_add)
		: 1'b0;
	assign new_flags.n = res8[7];
	assign new_flags.z = st_wait ? ((res8 == 8'h00) && (lo_res == 8'h00))
		: (res8 == 8'h00);
	assign new_flags.s = res8[7] ^ new_flags.v;

	// inc and dec leave carry alone
	wire [5:0] byte_mask = o_full ? alex_pkg::FM_ARITH
		: (o_ones ? alex_pkg::FM_ONES
		: (o_logic ? alex_pkg::FM_LOGIC : alex_pkg::FM_NONE));
	// word flags only on the final byte
	wire [5:0] flag_mask = st_wait ? (o_word ? alex_pkg::FM_WORD
		: alex_pkg::FM_NONE) : (st_exec && !o_word ? byte_mask
		: alex_pkg::FM_NONE);
	wire [5:0] upd_flags = (new_flags & flag_mask) | (flags & ~flag_mask);

	wire [15:0] rel_target = pc + {{4{offset[11]}}, offset} + 16'h0001;
	wire [15:0] ind_target = {rd_b, rd_a};

	// register file write arbitration; execution has the port while busy
	wire exe_we = (st_exec && !o_jump) || (st_wait && o_word);

	// bus write side
	wire wr_fire = aw_held & w_held & ~BVALID;
	wire sel_cmd = (aw_addr == alex_pkg::OFS_CMD);
	wire sel_oper = (aw_addr == alex_pkg::OFS_OPER);
	wire sel_ofs = (aw_addr == alex_pkg::OFS_OFFSET);
	wire sel_pc = (aw_addr == alex_pkg::OFS_PC);
	wire sel_flg = (aw_addr == alex_pkg::OFS_FLAGS);
	wire sel_stat = (aw_addr == alex_pkg::OFS_STATUS);
	wire sel_rw = (aw_addr == alex_pkg::OFS_REGWR);
	wire sel_peek = (aw_addr == alex_pkg::OFS_PEEK);
	wire wr_known = sel_cmd | sel_oper | sel_ofs | sel_pc | sel_flg
		| sel_stat | sel_rw | sel_peek;
	// state-steering registers are frozen while an operation runs
	wire wr_ok = wr_fire & idle;
	wire [31:0] wr_view = sel_cmd ? {27'h0, op}
		: (sel_oper ? {8'h00, opr.imm, 3'h0, opr.src, 3'h0, opr.dest}
		: (sel_ofs ? {20'h0, offset}
		: (sel_pc ? {16'h0, pc}
		: (sel_flg ? {26'h0, flags}
		: (sel_peek ? {19'h0, peek_idx, 8'h00} : 32'h0)))));
	wire [31:0] wr_val = alex_pkg::merge_strb(wr_view, w_data, w_strb);
	wire start = wr_ok & sel_cmd & w_strb[0];
	wire legal = (wr_val[4:0] <= alex_pkg::OP_LAST);
	wire host_we = wr_ok & sel_rw;

	wire rf_we = exe_we | host_we;
	wire [4:0] rf_waddr = exe_we ? (st_wait ? dest_hi : opr.dest)
		: wr_val[alex_pkg::REG_IDX_LSB +: 5];
	wire [7:0] rf_wdata = exe_we ? res8 : wr_val[7:0];

	// bus read side
	wire rd_take = ARVALID & ~RVALID;
	wire rsel_known = (ARADDR == alex_pkg::OFS_CMD)
		| (ARADDR == alex_pkg::OFS_OPER) | (ARADDR == alex_pkg::OFS_OFFSET)
		| (ARADDR == alex_pkg::OFS_PC) | (ARADDR == alex_pkg::OFS_FLAGS)
		| (ARADDR == alex_pkg::OFS_STATUS) | (ARADDR == alex_pkg::OFS_REGWR)
		| (ARADDR == alex_pkg::OFS_PEEK);
	wire [31:0] rd_view = (ARADDR == alex_pkg::OFS_CMD) ? {27'h0, op}
		: (ARADDR == alex_pkg::OFS_OPER)
		? {8'h00, opr.imm, 3'h0, opr.src, 3'h0, opr.dest}
		: (ARADDR == alex_pkg::OFS_OFFSET) ? {20'h0, offset}
		: (ARADDR == alex_pkg::OFS_PC) ? {16'h0, pc}
		: (ARADDR == alex_pkg::OFS_FLAGS) ? {26'h0, flags}
		: (ARADDR == alex_pkg::OFS_STATUS)
		? {16'h0, last_res, 6'h0, bad_op, ~idle}
		: (ARADDR == alex_pkg::OFS_PEEK) ? {19'h0, peek_idx, rd_a}
		: 32'h0;

	assign AWREADY = ~aw_held & ~BVALID;
	assign WREADY = ~w_held & ~BVALID;
	assign ARREADY = ~RVALID;

	alex_regfile u_regfile (
		.clk(CLK),
		.rst_n(RST_N),
		.addr_a(ra_addr),
		.addr_b(rb_addr),
		.rd_a(rd_a),
		.rd_b(rd_b),
		.we(rf_we),
		.waddr(rf_waddr),
		.wdata(rf_wdata)
	);

	// sequencing
	always_comb begin
		next_state = state;
		case (state)
			alex_pkg::ST_IDLE: begin
				if (start && legal) begin
					next_state = alex_pkg::ST_FETCH;
				end
			end
			alex_pkg::ST_FETCH: begin
				next_state = alex_pkg::ST_EXEC;
			end
			alex_pkg::ST_EXEC: begin
				if (o_word || o_jump) begin
					next_state = alex_pkg::ST_WAIT;
				end else begin
					next_state = alex_pkg::ST_IDLE;
				end
			end
			alex_pkg::ST_WAIT: begin
				if (cnt == 2'h0) begin
					next_state = alex_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = alex_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= alex_pkg::ST_IDLE;
			cnt <= 2'h0;
		end else begin
			state <= next_state;
			if (st_exec) begin
				cnt <= o_call ? 2'(alex_pkg::CYC_CALL - 2)
					: 2'(alex_pkg::CYC_JUMP - 2);
			end else if (st_wait && cnt != 2'h0) begin
				cnt <= cnt - 2'h1;
			end
		end
	end

	// software-visible control registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			op <= alex_pkg::OP_ADD;
			opr <= '0;
			offset <= 12'h000;
			peek_idx <= 5'h00;
			bad_op <= 1'b0;
		end else begin
			if (start) begin
				op <= wr_val[4:0];
				bad_op <= ~legal;
			end
			if (wr_ok && sel_oper) begin
				opr.dest <= wr_val[alex_pkg::OPER_DEST_LSB +: 5];
				opr.src <= wr_val[alex_pkg::OPER_SRC_LSB +: 5];
				opr.imm <= wr_val[alex_pkg::OPER_IMM_LSB +: 8];
			end
			if (wr_ok && sel_ofs) begin
				offset <= wr_val[11:0];
			end
			if (wr_fire && sel_peek) begin
				peek_idx <= wr_val[alex_pkg::REG_IDX_LSB +: 5];
			end
		end
	end

	// program counter, flags and result capture
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			pc <= alex_pkg::PC_RST;
			flags <= alex_pkg::FLAGS_RST;
			lo_res <= 8'h00;
			lo_carry <= 1'b0;
			last_res <= 8'h00;
		end else begin
			if (st_exec && o_jump) begin
				pc <= o_jrel ? rel_target : ind_target;
			end else if (wr_ok && sel_pc) begin
				pc <= wr_val[15:0];
			end
			if (!idle) begin
				flags <= upd_flags;
			end else if (wr_ok && sel_flg) begin
				flags <= wr_val[5:0];
			end
			if (st_exec) begin
				lo_res <= res8;
				lo_carry <= arith[8];
			end
			if (exe_we) begin
				last_res <= res8;
			end
		end
	end

	// axi4-lite handshakes
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= alex_pkg::RESP_OKAY;
			RVALID <= 1'b0;
			RDATA <= 32'h0;
			RRESP <= alex_pkg::RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_held <= 1'b1;
				w_data <= WDATA;
				w_strb <= WSTRB;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
			if (wr_fire) begin
				BVALID <= 1'b1;
				BRESP <= wr_known ? alex_pkg::RESP_OKAY
					: alex_pkg::RESP_SLVERR;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
			if (rd_take) begin
				RVALID <= 1'b1;
				RDATA <= rd_view;
				RRESP <= rsel_known ? alex_pkg::RESP_OKAY
					: alex_pkg::RESP_SLVERR;
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end
endmodule // alex_core
`default_nettype wire

// [test/alex_core_asserts.sv]
// register bus checker for the alu execution block
`timescale 1ns/1ps
`default_nettype none
module alex_core_asserts (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic [alex_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [alex_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY
);
	logic ar_bad;
	// only addresses past the last word are unmapped here
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			ar_bad <= 1'b0;
		else if (ARVALID && ARREADY)
			ar_bad <= ARADDR > alex_pkg::OFS_PEEK;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_b_hold;
		BVALID && !BREADY |=> BVALID && $stable(BRESP);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped early");
	property p_r_hold;
		RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read response changed early");
	property p_w_block;
		BVALID |-> !AWREADY && !WREADY;
	endproperty
	a_w_block: assert property (p_w_block)
		else $error("write accepted while response pending");
	property p_ar_block;
		RVALID |-> !ARREADY;
	endproperty
	a_ar_block: assert property (p_ar_block)
		else $error("read accepted while response pending");
	property p_rd_answer;
		ARVALID && ARREADY |=> RVALID;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late");
	property p_b_answer;
		AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID;
	endproperty
	a_b_answer: assert property (p_b_answer)
		else $error("write answer late");
	property p_b_clear;
		BVALID && BREADY |=> !BVALID;
	endproperty
	a_b_clear: assert property (p_b_clear)
		else $error("write response repeated");
	property p_r_clear;
		RVALID && RREADY |=> !RVALID;
	endproperty
	a_r_clear: assert property (p_r_clear)
		else $error("read response repeated");
	property p_unmapped;
		RVALID && ar_bad |-> RRESP == alex_pkg::RESP_SLVERR && RDATA == '0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");
endmodule // alex_core_asserts
bind alex_core alex_core_asserts u_chk (.CLK(CLK), .RST_N(RST_N),
	.AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
	.WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
	.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
	.RREADY(RREADY));
`default_nettype wire

// [test/alex_core_tb.sv]
// self-checking bench for the alu execution block
`timescale 1ns/1ps
`default_nettype none
module alex_core_tb;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] k;
		logic [5:0] fin;
		logic [7:0] rlo;
		logic [7:0] rhi;
		logic [5:0] fout;
	} alex_row_s;
	logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic ARVALID, ARREADY, RVALID, RREADY;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, v;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, r;
	logic [15:0] jexp [4];
	logic [7:0] lr;
	alex_row_s rows [22];
	int n_mismatch = 0;
	int total_checks = 0;
	// edges of delay before bready or rready rise, 0 raises them at once
	int rdy_lag = 0;
	alex_core uut (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
		.WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
		.BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY));
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk({30'h0, got}, {30'h0, exp});
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] resp);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= (rdy_lag == 0);
		while (!(aw && w)) begin
			@(posedge CLK);
			if (!aw && AWREADY === 1'b1) begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (!w && WREADY === 1'b1) begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end
		if (rdy_lag != 0) begin
			repeat (rdy_lag) @(posedge CLK);
			BREADY <= 1'b1;
		end
		do
			@(posedge CLK);
		while (BVALID !== 1'b1);
		resp = BRESP;
		BREADY <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= (rdy_lag == 0);
		do
			@(posedge CLK);
		while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		if (rdy_lag != 0) begin
			repeat (rdy_lag) @(posedge CLK);
			RREADY <= 1'b1;
		end
		do
			@(posedge CLK);
		while (RVALID !== 1'b1);
		d = RDATA;
		resp = RRESP;
		RREADY <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] rs;
		axi_wr(a, d, rs);
		chk_resp(rs, alex_pkg::RESP_OKAY);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] rs;
		axi_rd(a, d, rs);
		chk_resp(rs, alex_pkg::RESP_OKAY);
	endtask
	task automatic setreg(input logic [4:0] idx, input logic [7:0] val);
		wr(alex_pkg::OFS_REGWR, {19'h0, idx, val});
	endtask
	task automatic getreg(input logic [4:0] idx, output logic [31:0] d);
		wr(alex_pkg::OFS_PEEK, {19'h0, idx, 8'h00});
		rd(alex_pkg::OFS_PEEK, d);
		d = {24'h0, d[7:0]};
	endtask
	task automatic run(input logic [4:0] op);
		logic [31:0] st;
		wr(alex_pkg::OFS_CMD, {27'h0, op});
		st = 32'h1;
		// bounded poll, a stuck busy shows as a mismatch
		for (int n = 0; n < 20 && st[0] !== 1'b0; n++)
			rd(alex_pkg::OFS_STATUS, st);
		chk({31'h0, st[0]}, 32'h0);
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		n_mismatch++;
		close_out();
	end
	initial begin
		// op code equals row index, operands dest 2, src 3
		rows = '{
			'{8'h0f, 8'h01, 8'h00, 6'h10, 8'h10, 8'h01, 6'h30},
			'{8'h7f, 8'h00, 8'h00, 6'h01, 8'h80, 8'h00, 6'h2c},
			'{8'hff, 8'h7f, 8'h01, 6'h20, 8'h00, 8'h80, 6'h2c},
			'{8'h10, 8'h01, 8'h00, 6'h00, 8'h0f, 8'h01, 6'h20},
			'{8'h00, 8'h00, 8'h01, 6'h00, 8'hff, 8'h00, 6'h25},
			'{8'h00, 8'h00, 8'h01, 6'h00, 8'hff, 8'hff, 6'h15},
			'{8'h80, 8'h00, 8'h00, 6'h01, 8'h7f, 8'h00, 6'h28},
			'{8'h01, 8'h00, 8'h01, 6'h02, 8'h00, 8'h00, 6'h02},
			'{8'hf0, 8'h3c, 8'h00, 6'h09, 8'h30, 8'h3c, 6'h01},
			'{8'h80, 8'h00, 8'h0f, 6'h21, 8'h00, 8'h00, 6'h23},
			'{8'h80, 8'h01, 8'h00, 6'h00, 8'h81, 8'h01, 6'h04},
			'{8'h00, 8'h00, 8'h00, 6'h10, 8'h00, 8'h00, 6'h12},
			'{8'hff, 8'h0f, 8'h00, 6'h08, 8'hf0, 8'h0f, 6'h04},
			'{8'h00, 8'h00, 8'h00, 6'h20, 8'hff, 8'h00, 6'h25},
			'{8'h01, 8'h00, 8'h00, 6'h00, 8'hff, 8'h00, 6'h25},
			'{8'h40, 8'h00, 8'h81, 6'h01, 8'hc1, 8'h00, 6'h05},
			'{8'hff, 8'h00, 8'hff, 6'h04, 8'h00, 8'h00, 6'h02},
			'{8'h7f, 8'h00, 8'h00, 6'h01, 8'h80, 8'h00, 6'h0d},
			'{8'h80, 8'h00, 8'h00, 6'h01, 8'h7f, 8'h00, 6'h09},
			'{8'h00, 8'h00, 8'h00, 6'h00, 8'h00, 8'h00, 6'h02},
			'{8'h55, 8'h00, 8'h00, 6'h0c, 8'h00, 8'h00, 6'h02},
			'{8'h12, 8'h00, 8'h00, 6'h3f, 8'hff, 8'h00, 6'h3f}};
		jexp = '{16'hf901, 16'h1234, 16'h0000, 16'h1234};
		RST_N = 1'b0;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
		AWADDR = 8'h00;
		ARADDR = 8'h00;
		WDATA = 32'h0;
		WSTRB = 4'hf;
		repeat (16) @(posedge CLK);
		RST_N <= 1'b1;
		rd(alex_pkg::OFS_PC, v);
		chk(v, {16'h0, alex_pkg::PC_RST});
		rd(alex_pkg::OFS_FLAGS, v);
		chk(v, {26'h0, alex_pkg::FLAGS_RST});
		for (int i = 0; i < 22; i++) begin
			setreg(5'd2, rows[i].a);
			setreg(5'd3, rows[i].b);
			wr(alex_pkg::OFS_OPER, {8'h0, rows[i].k, 8'h03, 8'h02});
			wr(alex_pkg::OFS_FLAGS, {26'h0, rows[i].fin});
			run(5'(i));
			getreg(5'd2, v);
			chk(v, {24'h0, rows[i].rlo});
			getreg(5'd3, v);
			chk(v, {24'h0, rows[i].rhi});
			rd(alex_pkg::OFS_FLAGS, v);
			chk(v, {26'h0, rows[i].fout});
			// word ops write the upper byte last
			lr = (i == 2 || i == 5) ? rows[i].rhi : rows[i].rlo;
			rd(alex_pkg::OFS_STATUS, v);
			chk({24'h0, v[15:8]}, {24'h0, lr});
		end
		// pair at the top of the file wraps to register 0
		setreg(5'd31, 8'hff);
		setreg(5'd0, 8'h00);
		wr(alex_pkg::OFS_OPER, {8'h0, 8'h01, 8'h00, 8'h1f});
		run(alex_pkg::OP_ADDW);
		getreg(5'd31, v);
		chk(v, 32'h0);
		getreg(5'd0, v);
		chk(v, 32'h1);
		setreg(alex_pkg::Z_LO_IDX, 8'h34);
		setreg(alex_pkg::Z_HI_IDX, 8'h12);
		for (int i = 0; i < 4; i++) begin
			wr(alex_pkg::OFS_PC, i == 2 ? 32'hfffe : 32'h0100);
			wr(alex_pkg::OFS_OFFSET, i == 0 ? 32'h800 : 32'h001);
			wr(alex_pkg::OFS_FLAGS, 32'h2a);
			run(alex_pkg::OP_JREL + 5'(i));
			rd(alex_pkg::OFS_PC, v);
			chk(v, {16'h0, jexp[i]});
			rd(alex_pkg::OFS_FLAGS, v);
			chk(v, 32'h2a);
		end
		// code past the last operation must not start
		wr(alex_pkg::OFS_CMD, 32'h1a);
		rd(alex_pkg::OFS_STATUS, v);
		chk({30'h0, v[1:0]}, 32'h2);
		// slow ready from here on, responses must stand meanwhile
		rdy_lag = 2;
		axi_rd(8'h40, v, r);
		chk_resp(r, alex_pkg::RESP_SLVERR);
		chk(v, 32'h0);
		axi_wr(8'h40, 32'hffff_ffff, r);
		chk_resp(r, alex_pkg::RESP_SLVERR);
		@(posedge CLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		rd(alex_pkg::OFS_PC, v);
		chk(v, {16'h0, alex_pkg::PC_RST});
		close_out();
	end
endmodule // alex_core_tb
`default_nettype wire
